// ==== ccp_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccp_checker (
    input wire logic        hclk,             // bus clock
    input wire logic        hresetn,          // async reset, low
    input wire logic        hsel,             // slave select
    input wire logic [31:0] haddr,            // byte address
    input wire logic [1:0]  htrans,           // transfer type
    input wire logic        hwrite,           // write when high
    input wire logic [31:0] hwdata,           // write data
    input wire logic        hready,           // bus ready
    input wire logic        hreadyout,        // slave ready
    input wire logic        hresp,            // slave response
    input wire logic        channel0_pin_oe,  // pin 0 enable
    input wire logic        channel1_pin_oe,  // pin 1 enable
    input wire logic        channel1_pin_out, // pin 1 drive
    input wire logic        overflow_irq,     // overflow request
    input wire logic        channel0_irq,     // channel 0 request
    input wire logic        channel1_irq      // channel 1 request
);
    // ************************************************************
    // register shadows rebuilt from bus writes
    // ************************************************************
    logic       wr_q;   // write data phase pending
    logic [7:0] a_q;    // address of that phase
    logic [7:0] main_q; // main control shadow
    logic [7:0] c0_q;   // channel 0 control shadow
    logic [7:0] c1_q;   // channel 1 control shadow
    wire logic  w_m  = wr_q && a_q == ccp_pkg::main_control_status_addr;
    wire logic  w_c0 = wr_q && a_q == ccp_pkg::channel0_control_addr;
    wire logic  w_c1 = wr_q && a_q == ccp_pkg::channel1_control_addr;
    // shadows let request gating be judged without the bodies
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            a_q    <= 8'h00;
            main_q <= 8'h00;
            c0_q   <= 8'h00;
            c1_q   <= 8'h00;
        end else if (hready) begin
            wr_q   <= hsel && htrans[1] && hwrite;
            a_q    <= haddr[7:0];
            main_q <= w_m ? hwdata[7:0] : main_q;
            c0_q   <= w_c0 ? hwdata[7:0] : c0_q;
            c1_q   <= w_c1 ? hwdata[7:0] : c1_q;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // pin outputs lag the control write by up to two cycles
    sequence linked_held;
        c0_q[5] [*3];
    endsequence
    sequence ch0_capture_held;
        (c0_q[5:4] == 2'b00) [*3];
    endsequence
    sequence ch1_idle_held;
        (c1_q[5:4] == 2'b00 && !c0_q[5]) [*4];
    endsequence
    AST_READY: assert property (hreadyout)
        else $error("slave ready dropped");
    AST_RESP: assert property (!hresp)
        else $error("slave gave error response");
    AST_OVF_GATE: assert property (overflow_irq |-> main_q[6] || $past(main_q[6]))
        else $error("overflow request while disabled");
    AST_OVF_DROP: assert property ($fell(main_q[6]) |-> ##[0:1] !overflow_irq)
        else $error("overflow request outlived enable");
    AST_CH0_GATE: assert property (channel0_irq |-> c0_q[6] || $past(c0_q[6]))
        else $error("channel 0 request while disabled");
    AST_CH1_GATE: assert property (channel1_irq |-> c1_q[6] || $past(c1_q[6]))
        else $error("channel 1 request while disabled");
    AST_CH1_FREE: assert property (linked_held |-> !channel1_pin_oe)
        else $error("pin 1 driven while linked");
    AST_CH0_INPUT: assert property (ch0_capture_held |-> !channel0_pin_oe)
        else $error("pin 0 driven in capture mode");
    AST_CH1_QUIET: assert property (ch1_idle_held |-> $stable(channel1_pin_out))
        else $error("pin 1 moved without compare mode");
endmodule
bind capture_compare_unit ccp_checker chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp),
    .channel0_pin_oe(channel0_pin_oe), .channel1_pin_oe(channel1_pin_oe),
    .channel1_pin_out(channel1_pin_out), .overflow_irq(overflow_irq),
    .channel0_irq(channel0_irq), .channel1_irq(channel1_irq)
);
`default_nettype wire

// ==== ccp_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// tick and counter shared from the timebase to the channels
interface ccp_if;
    logic        tick;        // prescaled counter clock enable
    logic        overflow;    // counter at modulo on this tick
    logic [15:0] count;       // current counter value
    modport source (output tick, output overflow, output count);
    modport sink   (input tick, input overflow, input count);
endinterface
`default_nettype wire

// ==== ccp_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccp_pin_model (
    input  wire logic [1:0] drive_out, // design pin drive
    input  wire logic [1:0] drive_oe,  // design pin enable
    input  wire logic [1:0] source,    // external event level
    output logic      [1:0] pin        // resolved pin level
);
    // an event source only wins while the design lets the pin go
    assign pin = (drive_oe & drive_out) | (~drive_oe & source);
endmodule
`default_nettype wire

// ==== ccp_pkg.sv ====
// Notes on behaviour
// - capture edge copies counter into channel value
// - capture edge polarity selectable; capture raises request
// - counter equal value sets, clears or toggles pin
// - unbuffered value write takes effect at once
// - link bit pairs channels on channel 0 pin
// - channel 1 write takes over at next overflow
// - linked: channel 0 control governs, pin 1 freed
// - toggle-on-overflow toggles pin at modulo value
// - period follows modulo and prescaler choice
// - channel value sets pulse width from overflow
// - buffered pwm switches pair at period boundary
// - toggle-on-overflow clear gives constant output
// - max duty with toggle-on-overflow gives full duty
// - modulo match sets overflow flag, counter restarts
// - event flag per channel; request gated by enable
// - stop with counter reset halts counter at zero
package ccp_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] main_control_status_addr = 8'h00;
    localparam logic [7:0] counter_addr             = 8'h04;
    localparam logic [7:0] modulo_regs_addr         = 8'h08;
    localparam logic [7:0] channel0_control_addr    = 8'h0c;
    localparam logic [7:0] channel0_value_addr      = 8'h10;
    localparam logic [7:0] channel1_control_addr    = 8'h14;
    localparam logic [7:0] channel1_value_addr      = 8'h18;
    // ************************************************************
    // main control fields
    // ************************************************************
    localparam int overflow_flag_bit    = 7;
    localparam int overflow_irq_en_bit  = 6;
    localparam int counter_halt_bit_pos = 5;
    localparam int counter_reset_bit    = 4;
    localparam logic [7:0] main_reset_value = 8'h20;
    // ************************************************************
    // channel control fields, modulo reset value and prescale limit
    // ************************************************************
    localparam int event_flag_bit = 7;
    localparam int irq_enable_bit = 6;
    localparam int mode_b_bit     = 5;
    localparam int mode_a_bit     = 4;
    localparam int edge_b_bit     = 3;
    localparam int edge_a_bit     = 2;
    localparam int tov_bit        = 1;
    localparam int max_duty_pos   = 0;
    localparam logic [15:0] modulo_reset_value = 16'hffff;
    localparam logic [2:0]  prescale_limit     = 3'h6;
endpackage

// ==== ccp_timebase.sv ====
`timescale 1ns/1ns
`default_nettype none
module ccp_timebase (
    input  wire logic  hclk,          // bus clock
    input  wire logic  hresetn,       // async reset, low
    input  wire logic  halt,          // counter stopped
    input  wire logic  clear,         // counter and prescaler reset
    input  wire logic [2:0]  prescale,  // divide select
    input  wire logic [15:0] modulo,    // modulo value
    ccp_if.source      tb             // tick, overflow, count
);
    logic [5:0]  div_q;
    logic [15:0] count_q;
    logic        tick_w;
    logic [5:0]  mask_w;

    // divide by two to the prescale; code 7 stalls the counter
    assign mask_w = 6'((7'h01 << prescale) - 7'h01);
    assign tick_w = !halt && !clear && (prescale <= ccp_pkg::prescale_limit)
                    && ((div_q & mask_w) == mask_w);
    assign tb.tick     = tick_w;
    assign tb.count    = count_q;
    assign tb.overflow = tick_w && (count_q == modulo);

    // counter restarts from zero on the tick after the modulo match
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q   <= '0;
            count_q <= '0;
        end else if (clear) begin
            div_q   <= '0;
            count_q <= '0;
        end else if (!halt) begin
            div_q   <= div_q + 6'h01;
            if (tick_w)
                count_q <= (count_q == modulo) ? '0 : count_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== ccp_top.sv ====
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module capture_compare_unit (
    input  wire logic        hclk,         // bus clock
    input  wire logic        hresetn,      // async reset, low
    input  wire logic        hsel,         // slave select
    input  wire logic [31:0] haddr,        // byte address
    input  wire logic [1:0]  htrans,       // transfer type
    input  wire logic        hwrite,       // write when high
    input  wire logic [2:0]  hsize,        // word only
    input  wire logic [31:0] hwdata,       // write data
    input  wire logic        hready,       // bus ready in
    output logic      [31:0] hrdata,       // read data
    output logic             hreadyout,    // always ready
    output logic             hresp,        // always okay
    input  wire logic        channel0_pin_in,  // pin 0 level
    input  wire logic        channel1_pin_in,  // pin 1 level
    output logic             channel0_pin_out, // pin 0 drive
    output logic             channel0_pin_oe,  // pin 0 enable
    output logic             channel1_pin_out, // pin 1 drive
    output logic             channel1_pin_oe,  // pin 1 enable
    output logic             overflow_irq,     // overflow request
    output logic             channel0_irq,     // channel 0 request
    output logic             channel1_irq      // channel 1 request
);
    ccp_if tb ();

    // ************************************************************
    // bus slave: address phase captured, data phase acts
    // ************************************************************
    logic        wr_q, rd_q;
    logic [7:0]  addr_q;
    logic        addr_ok_w;
    assign addr_ok_w = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= '0;
        end else begin
            wr_q   <= addr_ok_w && hwrite;
            rd_q   <= addr_ok_w && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    logic wr_main_w, wr_mod_w, wr_c0_w, wr_v0_w, wr_c1_w, wr_v1_w, rd_main_w;
    assign wr_main_w = wr_q && hit(addr_q, ccp_pkg::main_control_status_addr);
    assign wr_mod_w  = wr_q && hit(addr_q, ccp_pkg::modulo_regs_addr);
    assign wr_c0_w   = wr_q && hit(addr_q, ccp_pkg::channel0_control_addr);
    assign wr_v0_w   = wr_q && hit(addr_q, ccp_pkg::channel0_value_addr);
    assign wr_c1_w   = wr_q && hit(addr_q, ccp_pkg::channel1_control_addr);
    assign wr_v1_w   = wr_q && hit(addr_q, ccp_pkg::channel1_value_addr);
    assign rd_main_w = rd_q && hit(addr_q, ccp_pkg::main_control_status_addr);

    // ************************************************************
    // main control and counter
    // ************************************************************
    logic        ovf_flag_q, ovf_ie_q, halt_q, ovf_armed_q;
    logic [2:0]  ps_q;
    logic [15:0] modulo_q;
    logic        clear_w;
    assign clear_w = wr_main_w && hwdata[ccp_pkg::counter_reset_bit];

    ccp_timebase timebase (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .halt     (halt_q),
        .clear    (clear_w),
        .prescale (ps_q),
        .modulo   (modulo_q),
        .tb       (tb)
    );

    // flag clears by read-then-write-zero; a new overflow wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_flag_q  <= 1'b0;
            ovf_armed_q <= 1'b0;
            ovf_ie_q    <= 1'b0;
            halt_q      <= ccp_pkg::main_reset_value[ccp_pkg::counter_halt_bit_pos];
            ps_q        <= '0;
            modulo_q    <= ccp_pkg::modulo_reset_value;
        end else begin
            if (tb.overflow) begin
                ovf_flag_q  <= 1'b1;
                ovf_armed_q <= 1'b0;
            end else if (wr_main_w && ovf_armed_q
                         && !hwdata[ccp_pkg::overflow_flag_bit]) begin
                ovf_flag_q  <= 1'b0;
                ovf_armed_q <= 1'b0;
            end else if (rd_main_w && ovf_flag_q) begin
                ovf_armed_q <= 1'b1;
            end
            if (wr_main_w) begin
                ovf_ie_q <= hwdata[ccp_pkg::overflow_irq_en_bit];
                halt_q   <= hwdata[ccp_pkg::counter_halt_bit_pos];
                ps_q     <= hwdata[2:0];
            end
            if (wr_mod_w)
                modulo_q <= hwdata[15:0];
        end
    end

    // ************************************************************
    // channel controls and values
    // ************************************************************
    logic [7:0]  ctl_q [2];
    logic [15:0] val_q [2];
    logic        ev_w [2];
    logic        ch_flag_q [2];
    logic        armed_q [2];
    logic        pin_q [2];
    logic        pin_in_q [2];
    logic        use1_q, pend1_q;
    logic        linked_w;
    logic [15:0] cmp0_w;
    logic        pin_raw_w [2];
    logic [15:0] next_cnt_w;

    assign linked_w     = ctl_q[0][ccp_pkg::mode_b_bit];
    assign pin_raw_w[0] = channel0_pin_in;
    assign pin_raw_w[1] = channel1_pin_in;
    // linked pair: whichever value was written last before the latest overflow drives channel 0
    assign cmp0_w = (linked_w && use1_q) ? val_q[1] : val_q[0];
    // match on the value the counter steps onto, so width equals value
    assign next_cnt_w = tb.overflow ? '0 : 16'(tb.count + 16'h0001);

    // pair handover at overflow, only after a write to the value not in use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            use1_q  <= 1'b0;
            pend1_q <= 1'b0;
        end else if (!linked_w) begin
            use1_q  <= 1'b0;
            pend1_q <= 1'b0;
        end else begin
            if (wr_v1_w)
                pend1_q <= 1'b1;
            else if (wr_v0_w)
                pend1_q <= 1'b0;
            if (tb.overflow)
                use1_q <= wr_v1_w || (pend1_q && !wr_v0_w);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : chan
            logic [7:0]  c_w;
            logic        capture_w, compare_w, active_w;
            logic        output_w, edge_w, rise_w, fall_w;
            logic        wr_ctl_w, wr_val_w, rd_ctl_w, next_pin_w;
            logic [15:0] cmp_w;

            // channel 1 goes idle while linked, its pin released
            assign active_w = (g == 0) || !linked_w;
            assign c_w      = ctl_q[g];
            assign wr_ctl_w = (g == 0) ? wr_c0_w : wr_c1_w;
            assign wr_val_w = (g == 0) ? wr_v0_w : wr_v1_w;
            assign rd_ctl_w = rd_q && hit(addr_q, (g == 0)
                ? ccp_pkg::channel0_control_addr
                : ccp_pkg::channel1_control_addr);
            assign cmp_w    = (g == 0) ? cmp0_w : val_q[g];
            assign output_w = active_w && (c_w[ccp_pkg::mode_b_bit]
                              || c_w[ccp_pkg::mode_a_bit]);
            assign rise_w   = channel_rise(pin_in_q[g], pin_raw_w[g]);
            assign fall_w   = channel_rise(pin_raw_w[g], pin_in_q[g]);
            assign edge_w   = (c_w[ccp_pkg::edge_a_bit] && rise_w)
                           || (c_w[ccp_pkg::edge_b_bit] && fall_w);
            assign capture_w = active_w && !output_w && edge_w;
            assign compare_w = output_w && tb.tick
                               && (next_cnt_w == cmp_w);
            assign ev_w[g]   = capture_w || compare_w;

            // overflow toggle, then compare action; max duty with overflow toggle holds high
            always_comb begin
                next_pin_w = pin_q[g];
                if (tb.overflow && c_w[ccp_pkg::tov_bit])
                    next_pin_w = !pin_q[g];
                if (compare_w) begin
                    case ({c_w[ccp_pkg::edge_b_bit], c_w[ccp_pkg::edge_a_bit]})
                        2'b01:   next_pin_w = !next_pin_w;
                        2'b10:   next_pin_w = 1'b0;
                        2'b11:   next_pin_w = 1'b1;
                        default: next_pin_w = next_pin_w;
                    endcase
                end
                if (c_w[ccp_pkg::max_duty_pos] && c_w[ccp_pkg::tov_bit])
                    next_pin_w = 1'b1;
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ctl_q[g]     <= '0;
                    val_q[g]     <= '0;
                    ch_flag_q[g] <= 1'b0;
                    armed_q[g]   <= 1'b0;
                    pin_q[g]     <= 1'b0;
                    pin_in_q[g]  <= 1'b0;
                end else begin
                    pin_in_q[g] <= pin_raw_w[g];
                    pin_q[g]    <= output_w ? next_pin_w : pin_q[g];
                    if (ev_w[g]) begin
                        ch_flag_q[g] <= 1'b1;
                        armed_q[g]   <= 1'b0;
                    end else if (wr_ctl_w && armed_q[g]
                                 && !hwdata[ccp_pkg::event_flag_bit]) begin
                        ch_flag_q[g] <= 1'b0;
                        armed_q[g]   <= 1'b0;
                    end else if (rd_ctl_w && ch_flag_q[g]) begin
                        armed_q[g] <= 1'b1;
                    end
                    if (wr_ctl_w)
                        ctl_q[g] <= {1'b0, hwdata[6:0]};
                    if (capture_w)
                        val_q[g] <= tb.count;
                    else if (wr_val_w)
                        val_q[g] <= hwdata[15:0];
                end
            end
        end
    endgenerate

    function automatic logic channel_rise(input logic was, input logic now);
        return !was && now;
    endfunction

    // ************************************************************
    // read mux and registered outputs
    // ************************************************************
    logic [31:0] rd_w;
    always_comb begin
        rd_w = '0;
        case (haddr[7:0])
            ccp_pkg::main_control_status_addr:
                rd_w = {24'h0, ovf_flag_q, ovf_ie_q, halt_q, 2'b00, ps_q};
            ccp_pkg::counter_addr:
                rd_w = {16'h0, tb.count};
            ccp_pkg::modulo_regs_addr:
                rd_w = {16'h0, modulo_q};
            ccp_pkg::channel0_control_addr:
                rd_w = {24'h0, ch_flag_q[0], ctl_q[0][6:0]};
            ccp_pkg::channel0_value_addr:
                rd_w = {16'h0, val_q[0]};
            ccp_pkg::channel1_control_addr:
                rd_w = {24'h0, ch_flag_q[1], ctl_q[1][6:0]};
            ccp_pkg::channel1_value_addr:
                rd_w = {16'h0, val_q[1]};
            default:
                rd_w = '0;
        endcase
    end

    // read data registered in the data phase; slave never stalls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata           <= '0;
            hreadyout        <= 1'b1;
            hresp            <= 1'b0;
            channel0_pin_out <= 1'b0;
            channel0_pin_oe  <= 1'b0;
            channel1_pin_out <= 1'b0;
            channel1_pin_oe  <= 1'b0;
            overflow_irq     <= 1'b0;
            channel0_irq     <= 1'b0;
            channel1_irq     <= 1'b0;
        end else begin
            hrdata           <= (addr_ok_w && !hwrite) ? rd_w : hrdata;
            hreadyout        <= 1'b1;
            hresp            <= 1'b0;
            channel0_pin_out <= pin_q[0];
            channel0_pin_oe  <= chan[0].output_w;
            channel1_pin_out <= pin_q[1];
            channel1_pin_oe  <= chan[1].output_w;
            overflow_irq     <= ovf_flag_q && ovf_ie_q;
            channel0_irq     <= ch_flag_q[0] && ctl_q[0][ccp_pkg::irq_enable_bit];
            channel1_irq     <= ch_flag_q[1] && ctl_q[1][ccp_pkg::irq_enable_bit]
                                && !linked_w;
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ************************************************************
    // bench signals
    // ************************************************************
    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans, ev;
    logic [2:0]  hsize;
    logic [7:0]  c;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, ovf_irq, c0_irq, c1_irq;
    wire logic [1:0]  pin_out, pin_oe, pin;
    int          miscompares, total_checks, n, hi, lo;
    time         t1;
    logic [7:0]  act [4] = '{8'h18, 8'h1c, 8'h14, 8'h1b};
    int          high [4] = '{0, 512, 256, 512};
    int          wid [2] = '{128, 16};
    // single slave, so its ready is the bus ready
    capture_compare_unit DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .channel0_pin_in(pin[0]), .channel1_pin_in(pin[1]),
        .channel0_pin_out(pin_out[0]), .channel0_pin_oe(pin_oe[0]),
        .channel1_pin_out(pin_out[1]), .channel1_pin_oe(pin_oe[1]),
        .overflow_irq(ovf_irq), .channel0_irq(c0_irq), .channel1_irq(c1_irq)
    );
    ccp_pin_model far (.drive_out(pin_out), .drive_oe(pin_oe),
                       .source(ev), .pin(pin));
    // free running bus clock
    always #5 hclk = ~hclk;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    // 0 overflow request, 1 pin 0 low, 2 pin 0 high, 3 bus ready
    function automatic logic probe(input int s);
        return (s == 0) ? ovf_irq : (s == 3) ? hreadyout
                                             : pin_out[0] ^ (s == 1);
    endfunction
    task automatic wait_on(input int s, output int k);
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (probe(s) !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            miscompares++;
            end_of_test;
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= 32'(a);
        htrans <= 2'b10;
        hwrite <= w;
        wait_on(3, n);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_on(3, n);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        check(exp, rd);
    endtask
    // software setup order: halt and clear, period, width, mode, start
    task automatic pwm(input logic [7:0] cc, input int w);
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0030);
        wr(ccp_pkg::modulo_regs_addr, 32'h0000_00ff);
        wr(ccp_pkg::channel0_value_addr, 32'(w));
        wr(ccp_pkg::channel0_control_addr, 32'(cc));
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0000);
    endtask
    task automatic measure;
        wait_on(1, n);
        wait_on(2, n);
        wait_on(1, hi);
        wait_on(2, lo);
    endtask
    // main sequence
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, ev} = '0;
        {haddr, hwdata, miscompares, total_checks} = '0;
        hsize = 3'b010;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(ccp_pkg::main_control_status_addr, 32'h0000_0020);
        rchk(ccp_pkg::modulo_regs_addr, 32'h0000_ffff);
        rchk(ccp_pkg::counter_addr, 32'h0000_0000);
        wr(8'h1c, 32'hffff_ffff);
        rchk(8'h1c, 32'h0000_0000);
        // overflow period, flag and request clearing
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0030);
        wr(ccp_pkg::modulo_regs_addr, 32'h0000_00ff);
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0040);
        wait_on(0, n);
        t1 = $time;
        rchk(ccp_pkg::main_control_status_addr, 32'h0000_00c0);
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0040);
        repeat (2) @(posedge hclk);
        check(0, ovf_irq);
        wait_on(0, n);
        check(256, 32'(($time - t1) / 10));
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0030);
        repeat (8) @(posedge hclk);
        rchk(ccp_pkg::counter_addr, 32'h0000_0000);
        // clear, set, toggle and full duty actions
        for (int k = 0; k < 4; k++) begin
            pwm(act[k], 128);
            repeat (300) @(posedge hclk);
            hi = 0;
            repeat (512) begin
                @(posedge hclk);
                hi += int'(pin_out[0] === 1'b1);
            end
            check(high[k], hi);
        end
        // unbuffered widths
        for (int k = 0; k < 2; k++) begin
            pwm(8'h5a, wid[k]);
            measure;
            check(wid[k], hi);
            check(256 - wid[k], lo);
        end
        // raise just after overflow, lower just after compare
        wr(ccp_pkg::channel0_value_addr, 32'h0000_0040);
        measure;
        check(64, hi);
        wait_on(1, n);
        wr(ccp_pkg::channel0_value_addr, 32'h0000_0020);
        measure;
        check(32, hi);
        // linked pair hands over at period boundaries
        pwm(8'h2a, 64);
        measure;
        check(64, hi);
        wr(ccp_pkg::channel1_value_addr, 32'h0000_00c0);
        measure;
        check(192, hi);
        wr(ccp_pkg::channel0_value_addr, 32'h0000_0020);
        measure;
        check(32, hi);
        check(0, pin_oe[1]);
        // captures on a halted counter at zero, edge codes 1 to 3
        wr(ccp_pkg::channel0_control_addr, 32'h0000_0000);
        wr(ccp_pkg::main_control_status_addr, 32'h0000_0030);
        for (int e = 1; e < 4; e++) begin
            c = ((e != 2) ? 8'h40 : 8'h00) | 8'(e << 2);
            wr(ccp_pkg::channel1_control_addr, 32'(c));
            wr(ccp_pkg::channel1_value_addr, 32'h0000_1234);
            ev[1] <= 1'b1;
            repeat (4) @(posedge hclk);
            rchk(ccp_pkg::channel1_value_addr, (e == 2) ? 32'h1234 : 0);
            ev[1] <= 1'b0;
            repeat (4) @(posedge hclk);
            rchk(ccp_pkg::channel1_value_addr, 32'h0000_0000);
            check(32'(e != 2), c1_irq);
            rchk(ccp_pkg::channel1_control_addr, 32'(c) | 32'h80);
            wr(ccp_pkg::channel1_control_addr, 32'(c));
            repeat (2) @(posedge hclk);
            check(0, c1_irq);
        end
        end_of_test;
    end
endmodule
`default_nettype wire
